// file: logic/mcpd_meter_driver.sv
// meter coil pwm driver: counter, double-buffered compares, routing
// assumes one-cycle register strobes on core_clk; port_data from port latches
`timescale 1ns/10ps
`default_nettype none
module mcpd_meter_driver #(
    parameter int METERS = mcpd_pkg::METERS
) (
    input wire logic core_clk, // 10 MHz main clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [15:0] reg_addr, // byte address
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, one cycle after reg_rd
    output logic reg_rvalid, // read data valid pulse
    input wire mcpd_pkg::mcpd_pins_t [METERS-1:0] port_data, // port latch values
    output mcpd_pkg::mcpd_pins_t [METERS-1:0] meter_pins, // meter coil pins
    output logic [METERS-1:0] sin_match, // sine compare match pulse
    output logic [METERS-1:0] cos_match, // cosine compare match pulse
    output logic [7:0] pwm_up_counter // counter value
);
    logic [7:0] timer_mode_q;
    logic [7:0] output_mode_q;
    logic [2:0] meter_clk_switch_q;
    mcpd_pkg::mcpd_ctrl_t [METERS-1:0] ctrl_q;
    logic [7:0] sin_master_q [METERS];
    logic [7:0] cos_master_q [METERS];
    logic [7:0] sin_slave_q [METERS];
    logic [7:0] cos_slave_q [METERS];
    logic [1:0] quad_q [METERS];
    logic [mcpd_pkg::PRESCALE_W-1:0] pre_q;
    logic [7:0] cnt_q;
    logic phase_q;
    logic counter_run;
    logic cnt_tick;
    logic ovf;
    logic switch_tick;
    logic [mcpd_pkg::PRESCALE_W-1:0] sw_mask;

    assign counter_run = timer_mode_q[mcpd_pkg::RUN_BIT];
    assign pwm_up_counter = cnt_q;

    // prescaler mask for the switch-selected rate, main clock over 2^(3+sel), capped at 2^9
    function automatic logic [mcpd_pkg::PRESCALE_W-1:0] div_mask(input logic [2:0] sel);
        int e;
        e = mcpd_pkg::SWITCH_BASE_EXP + int'(sel);
        if (e > mcpd_pkg::SWITCH_MAX_EXP) begin
            e = mcpd_pkg::SWITCH_MAX_EXP;
        end
        return mcpd_pkg::PRESCALE_W'((1 << e) - 1);
    endfunction : div_mask

    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] base, input int i);
        return a == (base + 16'(i));
    endfunction : addr_hit

    assign sw_mask = div_mask(meter_clk_switch_q);
    assign switch_tick = (pre_q & sw_mask) == sw_mask;
    assign cnt_tick = counter_run &&
        (timer_mode_q[mcpd_pkg::CLK_SEL_BIT] ? pre_q[0] : switch_tick);
    assign ovf = cnt_tick && (cnt_q == mcpd_pkg::CNT_MAX);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !counter_run) begin
            cnt_q <= '0;
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || !counter_run) begin
            phase_q <= 1'b0;
        end else if (ovf) begin
            phase_q <= ~phase_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_mode_q <= mcpd_pkg::REG_RESET;
            output_mode_q <= mcpd_pkg::REG_RESET;
            meter_clk_switch_q <= '0;
        end else if (reg_wr) begin
            if (reg_addr == mcpd_pkg::TIMER_MODE_ADDR) begin
                timer_mode_q <= reg_wdata & mcpd_pkg::TIMER_MODE_MASK;
            end else if (reg_addr == mcpd_pkg::OUTPUT_MODE_ADDR) begin
                output_mode_q <= reg_wdata;
            end else if (reg_addr == mcpd_pkg::CLK_SWITCH_ADDR) begin
                meter_clk_switch_q <= reg_wdata[2:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int m = 0; m < METERS; m++) begin
                ctrl_q[m] <= '0;
                sin_master_q[m] <= mcpd_pkg::REG_RESET;
                cos_master_q[m] <= mcpd_pkg::REG_RESET;
                sin_slave_q[m] <= mcpd_pkg::REG_RESET;
                cos_slave_q[m] <= mcpd_pkg::REG_RESET;
                quad_q[m] <= 2'h0;
            end
        end else begin
            for (int m = 0; m < METERS; m++) begin
                if (ovf) begin
                    quad_q[m] <= {ctrl_q[m].quadrant_sel_hi, ctrl_q[m].quadrant_sel_lo};
                end
                // transfer then self-clear; a software set in the same cycle wins
                if (ovf && ctrl_q[m].transfer_enable) begin
                    sin_slave_q[m] <= sin_master_q[m];
                    cos_slave_q[m] <= cos_master_q[m];
                    ctrl_q[m].transfer_enable <= 1'b0;
                end
                if (reg_wr && addr_hit(reg_addr, mcpd_pkg::CTRL_BASE_ADDR, m)) begin
                    ctrl_q[m] <= reg_wdata & mcpd_pkg::CTRL_MASK;
                end
                // masters locked while a transfer is pending
                if (reg_wr && !ctrl_q[m].transfer_enable) begin
                    if (addr_hit(reg_addr, mcpd_pkg::CMP_BASE_ADDR, 2 * m)) begin
                        sin_master_q[m] <= reg_wdata;
                    end else if (addr_hit(reg_addr, mcpd_pkg::CMP_BASE_ADDR, 2 * m + 1)) begin
                        cos_master_q[m] <= reg_wdata;
                    end
                end
            end
        end
    end

    // read path; compare reads return the master value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                if (reg_addr == mcpd_pkg::TIMER_MODE_ADDR) begin
                    reg_rdata <= timer_mode_q;
                end else if (reg_addr == mcpd_pkg::OUTPUT_MODE_ADDR) begin
                    reg_rdata <= output_mode_q;
                end else if (reg_addr == mcpd_pkg::CLK_SWITCH_ADDR) begin
                    reg_rdata <= {5'h00, meter_clk_switch_q};
                end
                for (int m = 0; m < METERS; m++) begin
                    if (addr_hit(reg_addr, mcpd_pkg::CTRL_BASE_ADDR, m)) begin
                        reg_rdata <= ctrl_q[m];
                    end else if (addr_hit(reg_addr, mcpd_pkg::CMP_BASE_ADDR, 2 * m)) begin
                        reg_rdata <= sin_master_q[m];
                    end else if (addr_hit(reg_addr, mcpd_pkg::CMP_BASE_ADDR, 2 * m + 1)) begin
                        reg_rdata <= cos_master_q[m];
                    end
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < METERS; g++) begin : g_meter
            logic s_pwm;
            logic c_pwm;
            logic en;
            logic half;
            mcpd_pkg::mcpd_pins_t pins_d;
            assign en = output_mode_q[g];
            assign half = output_mode_q[g + METERS];
            // high from wrap until match; 255 gives full duty
            assign s_pwm = counter_run && ((cnt_q < sin_slave_q[g]) ||
                (sin_slave_q[g] == mcpd_pkg::CNT_MAX) ||
                (ctrl_q[g].sin_extra_bit_en && phase_q && cnt_q == sin_slave_q[g]));
            assign c_pwm = counter_run && ((cnt_q < cos_slave_q[g]) ||
                (cos_slave_q[g] == mcpd_pkg::CNT_MAX) ||
                (ctrl_q[g].cos_extra_bit_en && phase_q && cnt_q == cos_slave_q[g]));

            // pin routing per mode and quadrant
            always_comb begin
                pins_d = port_data[g];
                if (en) begin
                    pins_d = half ? port_data[g] : '0;
                    if (!quad_q[g][1]) begin
                        pins_d.sine_pos_pin = s_pwm;
                    end else begin
                        pins_d.sine_neg_pin = s_pwm;
                    end
                    if (quad_q[g][1] == quad_q[g][0]) begin
                        pins_d.cosine_pos_pin = c_pwm;
                    end else begin
                        pins_d.cosine_neg_pin = c_pwm;
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (rst) begin
                    meter_pins[g] <= '0;
                    sin_match[g] <= 1'b0;
                    cos_match[g] <= 1'b0;
                end else begin
                    meter_pins[g] <= pins_d;
                    sin_match[g] <= counter_run && cnt_q == sin_slave_q[g];
                    cos_match[g] <= counter_run && cnt_q == cos_slave_q[g];
                end
            end
        end
    endgenerate

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    stopped_clears_a: assert property (!counter_run |=> cnt_q == 8'h00)
        else $error("counter not cleared while stopped");
    reset_clears_a: assert property (disable iff (1'b0) rst |=> cnt_q == 8'h00 && timer_mode_q == 8'h00)
        else $error("reset left counter or mode set");
    counter_wraps_a: assert property (ovf |=> cnt_q == 8'h00)
        else $error("counter did not wrap");
    counter_steps_a: assert property (cnt_tick && cnt_q != 8'hFF |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter step wrong");
    half_rate_a: assert property ((counter_run && timer_mode_q[mcpd_pkg::CLK_SEL_BIT]) [*3]
        |-> cnt_q == $past(cnt_q, 2) + 8'h01)
        else $error("half clock rate not counting");
    slave_load_a: assert property (ovf && ctrl_q[0].transfer_enable |=>
        sin_slave_q[0] == $past(sin_master_q[0]) && (!ctrl_q[0].transfer_enable || $past(reg_wr)))
        else $error("slave not loaded at overflow");
    write_block_a: assert property (ctrl_q[0].transfer_enable && !ovf |=> $stable(sin_master_q[0]))
        else $error("master written while transfer pending");
    sin_match_a: assert property (counter_run && cnt_q == sin_slave_q[0] |=> sin_match[0])
        else $error("sine match missing");
    cos_match_a: assert property (counter_run && cnt_q != cos_slave_q[0] |=> !cos_match[0])
        else $error("false cosine match");
    port_mode_a: assert property (!output_mode_q[0] |=> meter_pins[0] == $past(port_data[0]))
        else $error("port mode pins wrong");
    quad_hold_a: assert property (!ovf |=> $stable(quad_q[0]))
        else $error("quadrant changed mid period");
    no_pulse_a: assert property (sin_slave_q[0] == 8'h00 && output_mode_q[0] && !output_mode_q[4] && !ctrl_q[0].sin_extra_bit_en |=> !meter_pins[0].sine_pos_pin && !meter_pins[0].sine_neg_pin)
        else $error("pulse before slave loaded");
    reset_regs_a: assert property (disable iff (1'b0) rst |=>
        meter_clk_switch_q == 3'h0 && output_mode_q == 8'h00 && ctrl_q[0] == 8'h00 && sin_slave_q[0] == 8'h00)
        else $error("reset left a register set");
    last_meter_a: assert property (counter_run && cnt_q == cos_slave_q[METERS-1] |=>
        cos_match[METERS-1])
        else $error("last meter cosine match missing");
    sine_route_a: assert property (output_mode_q[1] && !output_mode_q[5] &&
        quad_q[1][1] |=> !meter_pins[1].sine_pos_pin)
        else $error("sine pwm on wrong pin");
    cos_route_a: assert property (output_mode_q[1] && !output_mode_q[5] &&
        quad_q[1][1] != quad_q[1][0] |=> !meter_pins[1].cosine_pos_pin)
        else $error("cosine pwm on wrong pin");
    half_port_a: assert property (output_mode_q[1] && output_mode_q[5] &&
        !quad_q[1][1] |=> meter_pins[1].sine_neg_pin == $past(port_data[1].sine_neg_pin))
        else $error("half bridge idle pin not port");
    full_duty_a: assert property (counter_run && sin_slave_q[1] == 8'hFF &&
        output_mode_q[1] && !quad_q[1][1] |=> meter_pins[1].sine_pos_pin)
        else $error("full duty pin low");
    wrap_high_a: assert property (counter_run && cnt_q == 8'h00 &&
        sin_slave_q[0] != 8'h00 && output_mode_q[0] && !quad_q[0][1] |=>
        meter_pins[0].sine_pos_pin)
        else $error("pin low after wrap");
    match_low_a: assert property (counter_run && cnt_q == sin_slave_q[0] &&
        sin_slave_q[0] != 8'hFF && !ctrl_q[0].sin_extra_bit_en && output_mode_q[0] &&
        !quad_q[0][1] |=> !meter_pins[0].sine_pos_pin)
        else $error("pin high past match");
    extra_count_a: assert property (counter_run && ctrl_q[0].sin_extra_bit_en &&
        phase_q && cnt_q == sin_slave_q[0] && output_mode_q[0] && !quad_q[0][1] |=>
        meter_pins[0].sine_pos_pin)
        else $error("extra count missing");
    phase_flip_a: assert property (ovf |=> phase_q != $past(phase_q))
        else $error("extra bit phase did not flip");

    transfer_c: cover property (ovf && ctrl_q[0].transfer_enable);
    half_bridge_c: cover property (output_mode_q[0] && output_mode_q[4] && quad_q[0] == 2'h3);
    dither_c: cover property (ctrl_q[0].sin_extra_bit_en && phase_q && sin_match[0]);
    quad_move_c: cover property (ovf && quad_q[1] != {ctrl_q[1].quadrant_sel_hi, ctrl_q[1].quadrant_sel_lo});
    half_route_c: cover property (output_mode_q[1] && output_mode_q[5] && quad_q[1] == 2'h2);
endmodule : mcpd_meter_driver
`default_nettype wire

// file: logic/mcpd_pkg.sv
// constants, register map and field layout of the meter coil pwm driver
// assumes an 8-bit internal register port with 16-bit byte addresses
// Operation
// - shared 8-bit counter, increments, wraps
// - reset clears the counter
// - counter_run low stops and clears counter
// - counter_clk_sel picks switch clock or half
// - duty equals compare value over 255; the code gives compare value over 256, with 255 giving full duty
// - sine compare equality gives sine match
// - cosine compare equality gives cosine match
// - reset clears compare registers and slaves
// - counter compares slave, loaded at overflow
// - transfer_enable governs compare value writes
// - extra bit alternates on successive overflows
// - extra bit enables at bits 2, 3
// - eight channels, four meters, one counter
// - half bridge idle pins act as ports
// - reset clears timer_mode_reg
// - meter_clk_switch resets zero, 8-bit access
// - transfer at overflow, blocks writes, self-clears
// - port mode pins, full bridge idle zero
// - quadrant bits route sine and cosine pins
// - polarity changes only at counter overflow
package mcpd_pkg;
    localparam int METERS = 4;
    localparam logic [15:0] TIMER_MODE_ADDR = 16'hFFBF;
    localparam logic [15:0] OUTPUT_MODE_ADDR = 16'hFFCB;
    localparam logic [15:0] CTRL_BASE_ADDR = 16'hFFCC;
    localparam logic [15:0] CMP_BASE_ADDR = 16'hFFD0;
    localparam logic [15:0] CLK_SWITCH_ADDR = 16'hFFD8;
    localparam int RUN_BIT = 4;
    localparam int CLK_SEL_BIT = 5;
    localparam logic [7:0] TIMER_MODE_MASK = 8'h30;
    localparam logic [7:0] CTRL_MASK = 8'h1F;
    localparam logic [7:0] CLK_SWITCH_MASK = 8'h07;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam int PRESCALE_W = 9;
    localparam int SWITCH_BASE_EXP = 3;
    localparam int SWITCH_MAX_EXP = 9;

    // compare control register layout
    typedef struct packed {
        logic [2:0] zero;
        logic transfer_enable;
        logic cos_extra_bit_en;
        logic sin_extra_bit_en;
        logic quadrant_sel_hi;
        logic quadrant_sel_lo;
    } mcpd_ctrl_t;

    // the four pins of one meter
    typedef struct packed {
        logic cosine_neg_pin;
        logic cosine_pos_pin;
        logic sine_neg_pin;
        logic sine_pos_pin;
    } mcpd_pins_t;
endpackage : mcpd_pkg

// file: bench/mcpd_coil_model.sv
// coil model: high time, in clock cycles, of one meter pin
// assumes a registered pin and an arm level driven by the bench
`timescale 1ns/10ps
`default_nettype none
module mcpd_coil_model (
    input wire logic core_clk, // main clock
    input wire logic rst, // synchronous reset
    input wire logic arm, // measure while high
    input wire logic pin, // watched pin
    output logic [15:0] width, // last high time
    output logic width_valid // pulse per finished high time
);
    logic [15:0] run_q;
    logic low_seen_q;
    always_ff @(posedge core_clk) begin
        width_valid <= 1'b0;
        if (rst || !arm) begin
            run_q <= 16'h0000;
            low_seen_q <= 1'b0;
        end else if (!pin) begin
            // a pulse already running when armed is never reported
            if (low_seen_q && run_q != 16'h0000) begin
                width <= run_q;
                width_valid <= 1'b1;
            end
            run_q <= 16'h0000;
            low_seen_q <= 1'b1;
        end else if (low_seen_q) begin
            run_q <= run_q + 16'h0001;
        end
    end
endmodule : mcpd_coil_model
`default_nettype wire

// file: bench/meter_coil_pwm_driver_tb.sv
// bench of the meter coil pwm driver: register port, counter and pins
// assumes the package, the driver and the coil model are compiled first
`timescale 1ns/10ps
`default_nettype none
module meter_coil_pwm_driver_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    mcpd_pkg::mcpd_pins_t [3:0] port_data = '0;
    mcpd_pkg::mcpd_pins_t [3:0] meter_pins;
    logic [3:0] sin_match;
    logic [3:0] cos_match;
    logic [7:0] pwm_up_counter;
    logic [7:0] cnt_prev;
    logic [7:0] v0;
    logic [7:0] c0;
    logic [7:0] cs;
    logic [1:0] pq = 2'b00;
    logic arm = 1'b0;
    logic watch = 1'b0;
    logic [15:0] width;
    logic width_valid;
    logic [15:0] acc = 16'h0000;
    logic [31:0] seed = 32'hF189EFA0;
    logic [7:0] rq[$];
    logic [15:0] wq[$];
    int fail_count = 0;
    int checks = 0;
    int grp = 1;
    int got = 0;
    mcpd_meter_driver u_mcpd_meter_driver (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .port_data(port_data), .meter_pins(meter_pins),
        .sin_match(sin_match), .cos_match(cos_match), .pwm_up_counter(pwm_up_counter));
    mcpd_coil_model u_mcpd_coil_model (.core_clk(core_clk), .rst(rst), .arm(arm),
        .pin(meter_pins[0].sine_pos_pin), .width(width), .width_valid(width_valid));
    always #50 core_clk = ~core_clk;
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xorshift
    function automatic mcpd_pkg::mcpd_pins_t exp_pins(input logic [1:0] q, input logic h);
        mcpd_pkg::mcpd_pins_t e;
        // sine slave is full duty, cosine slave is zero duty
        e = h ? port_data[1] : 4'h0;
        if (q[1]) e.sine_neg_pin = 1'b1;
        else e.sine_pos_pin = 1'b1;
        if (q == 2'b00 || q == 2'b11) e.cosine_pos_pin = 1'b0;
        else e.cosine_neg_pin = 1'b0;
        return e;
    endfunction : exp_pins
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic give_up(input string what);
        fail_count++;
        $display("mismatch %s expected done seen timeout", what);
        end_sim();
    endtask : give_up
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : cmp_byte
    task automatic cmp_width(input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch pulse width expected %0d seen %0d", e, s);
        end
    endtask : cmp_width
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        wait_cyc(1);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        wait_cyc(1);
        reg_rd = 1'b0;
    endtask : rd
    task automatic drain;
        for (int i = 0; i < 3000 && wq.size() != 0; i++) @(posedge core_clk);
        if (wq.size() != 0) give_up("pulse wait");
        #1;
    endtask : drain
    task automatic wait_change;
        int i;
        cs = pwm_up_counter;
        for (i = 0; i < 1100 && pwm_up_counter === cs; i++) wait_cyc(1);
        if (i == 1100) give_up("counter wait");
    endtask : wait_change
    task automatic check_reset;
        cmp_byte("counter", 8'h00, pwm_up_counter);
        rd(mcpd_pkg::TIMER_MODE_ADDR, 8'h00);
        rd(mcpd_pkg::CLK_SWITCH_ADDR, 8'h00);
        rd(mcpd_pkg::OUTPUT_MODE_ADDR, 8'h00);
        rd(16'h0100, 8'h00);
        for (int i = 0; i < 8; i++) rd(mcpd_pkg::CMP_BASE_ADDR + 16'(i), 8'h00);
        for (int i = 0; i < 4; i++) rd(mcpd_pkg::CTRL_BASE_ADDR + 16'(i), 8'h00);
    endtask : check_reset
    always @(posedge core_clk) begin
        if (reg_rvalid === 1'b1 && rq.size() > 0) cmp_byte("reg_rdata", rq.pop_front(), reg_rdata);
        if (watch && sin_match[0] === 1'b1) cmp_byte("sin_match cause", v0, cnt_prev);
        if (watch && cos_match[0] === 1'b1) cmp_byte("cos_match cause", c0, cnt_prev);
        cnt_prev = pwm_up_counter;
        if (width_valid === 1'b1 && wq.size() > 0) begin
            acc = acc + width;
            got++;
            if (got == grp) begin
                cmp_width(wq.pop_front(), acc);
                acc = 16'h0000;
                got = 0;
            end
        end
    end
    initial begin
        wait_cyc(12);
        rst = 1'b0;
        check_reset();
        wr(mcpd_pkg::TIMER_MODE_ADDR, 8'hFF);
        rd(mcpd_pkg::TIMER_MODE_ADDR, mcpd_pkg::TIMER_MODE_MASK);
        wr(mcpd_pkg::TIMER_MODE_ADDR, 8'h00);
        wr(mcpd_pkg::CLK_SWITCH_ADDR, 8'hFF);
        rd(mcpd_pkg::CLK_SWITCH_ADDR, mcpd_pkg::CLK_SWITCH_MASK);
        wr(mcpd_pkg::CTRL_BASE_ADDR + 16'h0003, 8'hFF);
        rd(mcpd_pkg::CTRL_BASE_ADDR + 16'h0003, mcpd_pkg::CTRL_MASK);
        seed = xorshift(seed);
        v0 = (seed[7:0] == 8'h00 || seed[7:0] == 8'hFF) ? 8'h5A : seed[7:0];
        c0 = seed[15:8];
        port_data = seed[31:16];
        // byte writes only, both compares before the transfer
        wr(mcpd_pkg::CMP_BASE_ADDR, v0);
        wr(mcpd_pkg::CMP_BASE_ADDR + 16'h0001, c0);
        wr(mcpd_pkg::CMP_BASE_ADDR + 16'h0002, 8'hFF);
        wr(mcpd_pkg::CMP_BASE_ADDR + 16'h0003, 8'h00);
        wr(mcpd_pkg::OUTPUT_MODE_ADDR, 8'h03);
        wr(mcpd_pkg::CTRL_BASE_ADDR, 8'h10);
        wr(mcpd_pkg::CTRL_BASE_ADDR + 16'h0001, 8'h10);
        wr(mcpd_pkg::CMP_BASE_ADDR, ~v0);
        rd(mcpd_pkg::CMP_BASE_ADDR, v0);
        wr(mcpd_pkg::TIMER_MODE_ADDR, 8'h30);
        wait_cyc(256);
        cmp_byte("pins before load", 8'h00, {meter_pins[1], meter_pins[0]});
        wait_cyc(300);
        rd(mcpd_pkg::CTRL_BASE_ADDR, 8'h00);
        rd(mcpd_pkg::CTRL_BASE_ADDR + 16'h0001, 8'h00);
        watch = 1'b1;
        arm = 1'b1;
        wq.push_back({7'h00, v0, 1'b0});
        wq.push_back({7'h00, v0, 1'b0});
        drain();
        arm = 1'b0;
        wr(mcpd_pkg::CTRL_BASE_ADDR, 8'h04);
        grp = 2;
        arm = 1'b1;
        wq.push_back({6'h00, v0, 2'b10});
        drain();
        arm = 1'b0;
        for (int h = 0; h < 2; h++) begin
            for (int q = 0; q < 4; q++) begin
                seed = xorshift(seed);
                port_data = seed[31:16];
                wr(mcpd_pkg::OUTPUT_MODE_ADDR, {2'b00, h[0], 5'b00011});
                wait_cyc(2);
                cmp_byte("pins mode", {4'h0, exp_pins(pq, h[0])}, {4'h0, meter_pins[1]});
                wr(mcpd_pkg::CTRL_BASE_ADDR + 16'h0001, 8'(q));
                wait_cyc(2);
                // a small count means an overflow fell inside the write
                if (pwm_up_counter > 8'h03) begin
                    cmp_byte("pins held", {4'h0, exp_pins(pq, h[0])}, {4'h0, meter_pins[1]});
                end
                wait_cyc(520);
                pq = 2'(q);
                cmp_byte("pins quadrant", {4'h0, exp_pins(pq, h[0])}, {4'h0, meter_pins[1]});
            end
        end
        wr(mcpd_pkg::OUTPUT_MODE_ADDR, 8'h01);
        wait_cyc(2);
        cmp_byte("pins port", {4'h0, port_data[1]}, {4'h0, meter_pins[1]});
        cmp_byte("pins rest", {port_data[3], port_data[2]}, {meter_pins[3], meter_pins[2]});
        watch = 1'b0;
        rst = 1'b1;
        wait_cyc(2);
        rst = 1'b0;
        check_reset();
        for (int s = 0; s < 5; s++) begin
            wr(mcpd_pkg::CLK_SWITCH_ADDR, 8'(s));
            wr(mcpd_pkg::TIMER_MODE_ADDR, (s == 4) ? 8'h30 : 8'h10);
            wait_change();
            cmp_byte("counter first step", cs + 8'h01, pwm_up_counter);
            // one tick period is 2 at half rate, else 8 << s clocks
            wait_cyc((s == 4) ? 1 : (8 << s) - 1);
            cmp_byte("counter hold", cs + 8'h01, pwm_up_counter);
            wait_cyc(1);
            cmp_byte("counter step", cs + 8'h02, pwm_up_counter);
            wr(mcpd_pkg::TIMER_MODE_ADDR, 8'h00);
            wait_cyc(2);
            cmp_byte("counter stopped", 8'h00, pwm_up_counter);
        end
        wait_cyc(4);
        end_sim();
    end
endmodule : meter_coil_pwm_driver_tb
`default_nettype wire
